/* rtl/fbd_host.sv */
// Host controller driving the flash chip select, gate, strobe, address and data pins
// How it works
// - Read data sampled only with select, gate low
// - Writes: select low, strobe low, gate high
// - Id read: elevated A9, A1 low
// - Query instruction path uses plain writes
// - Protection verify puts block on A12-A17
// - Reset pin held low minimum pulse
`timescale 1ns/10ps
module fbd_host #(
  parameter int CNT_W = fbd_pkg::CNT_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire fbd_pkg::fbd_req_s req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [fbd_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_valid,
  output fbd_pkg::fbd_pins_s pins,
  input wire logic [fbd_pkg::DATA_W-1:0] dq_i
);
  import fbd_pkg::*;

  fbd_state_e state_reg, state_next;
  fbd_req_s req_reg;
  fbd_pins_s pins_reg, pins_next;
  logic [DATA_W-1:0] rsp_data_reg;
  logic rsp_valid_reg;
  logic tmr_done;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic [ADDR_W-1:0] flash_addr;
  logic [ADDR_W-1:0] id_addr;
  logic [ADDR_W-1:0] pv_addr;
  logic [DATA_W-1:0] wr_oe;
  logic [DATA_W-1:0] rd_oe;
  logic [DATA_W-1:0] low_addr_pin;
  logic [DATA_W-1:0] rd_word;
  logic take;
  logic hv_op;
  logic sample;
  fbd_req_s req_use;
  logic started_reg;
  logic boot_reg;

  // New request drives the pins from the take edge on
  assign req_use = take ? req : req_reg;

  // Address shaping per operation
  assign id_addr = ADDR_W'(req_use.addr[1]) << A0_BIT;
  assign pv_addr = (ADDR_W'(req_use.addr[BLK_LSB+BLK_W:BLK_LSB+1]) << BLK_LSB)
                 | (ADDR_W'(1) << A1_BIT);
  assign flash_addr = (req_use.op == FBD_OP_SIG_HV) ? id_addr :
                      (req_use.op == FBD_OP_PROT_VERIFY) ? pv_addr :
                      req_use.addr[ADDR_W:1];
  assign hv_op = (req_use.op == FBD_OP_SIG_HV) || (req_use.op == FBD_OP_PROT_VERIFY);

  // Byte mode: top data pin carries the low address bit
  assign low_addr_pin = DATA_W'(req_use.addr[0]) << (DATA_W - 1);
  assign rd_oe = req_use.word_mode ? '0 : (DATA_W'(1) << (DATA_W - 1));
  assign wr_oe = req_use.word_mode ? '1 : ({1'b1, {(DATA_W-8-1){1'b0}}, 8'hFF});

  // Read word shaping
  assign rd_word = (req_reg.op == FBD_OP_PROT_VERIFY) ? DATA_W'(dq_i[0]) :
                   req_reg.word_mode ? dq_i : {BYTE_ZERO, dq_i[7:0]};

  assign take = req_valid && (state_reg == FBD_ST_IDLE);
  assign req_ready = (state_reg == FBD_ST_IDLE);
  assign sample = (state_reg == FBD_ST_RD) && tmr_done;
  assign tmr_load = (state_next != state_reg) || !started_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_valid = rsp_valid_reg;
  assign pins = pins_reg;

  fbd_timer #(.W(CNT_W)) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .load(tmr_load),
    .value(tmr_value),
    .done(tmr_done)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FBD_ST_RST: if (tmr_done && started_reg) state_next = FBD_ST_RST_REC;
      FBD_ST_RST_REC: if (tmr_done) state_next = FBD_ST_DONE;
      FBD_ST_IDLE: begin
        if (take) begin
          case (req.op)
            FBD_OP_WRITE: state_next = FBD_ST_WR_SETUP;
            FBD_OP_SIG_HV, FBD_OP_PROT_VERIFY: state_next = FBD_ST_HV;
            FBD_OP_RESET: state_next = FBD_ST_RST;
            default: state_next = FBD_ST_RD;
          endcase
        end
      end
      FBD_ST_HV: if (tmr_done) state_next = FBD_ST_RD;
      FBD_ST_WR_SETUP: if (tmr_done) state_next = FBD_ST_WR_LOW;
      FBD_ST_WR_LOW: if (tmr_done) state_next = FBD_ST_WR_HOLD;
      FBD_ST_WR_HOLD: if (tmr_done) state_next = FBD_ST_DONE;
      FBD_ST_RD: if (tmr_done) state_next = FBD_ST_DONE;
      FBD_ST_DONE: state_next = FBD_ST_IDLE;
      default: state_next = FBD_ST_IDLE;
    endcase
  end

  always_comb begin
    case (state_next)
      FBD_ST_RST: tmr_value = CNT_W'(RST_CYC - 1);
      FBD_ST_RST_REC: tmr_value = CNT_W'(RST_REC_CYC - 1);
      FBD_ST_HV: tmr_value = CNT_W'(HV_CYC - 1);
      FBD_ST_WR_SETUP: tmr_value = CNT_W'(SETUP_CYC - 1);
      FBD_ST_WR_LOW: tmr_value = CNT_W'(WE_LOW_CYC - 1);
      FBD_ST_WR_HOLD: tmr_value = CNT_W'(HOLD_CYC - 1);
      FBD_ST_RD: tmr_value = CNT_W'(ACC_CYC - 1);
      default: tmr_value = '0;
    endcase
  end

  // Pin levels per phase
  always_comb begin
    pins_next = PINS_RESET;
    pins_next.reset_unprotect_n = (state_next != FBD_ST_RST);
    pins_next.word_sel = req_use.word_mode;
    pins_next.addr = flash_addr;
    case (state_next)
      FBD_ST_HV: begin
        pins_next.hv_select_en = 1'b1;
        pins_next.dq_o = low_addr_pin;
        pins_next.dq_oe = rd_oe;
      end
      FBD_ST_WR_SETUP, FBD_ST_WR_HOLD: begin
        pins_next.ce_n = 1'b0;
        pins_next.dq_o = req_use.word_mode ? req_use.wdata : (low_addr_pin | req_use.wdata);
        pins_next.dq_oe = wr_oe;
      end
      FBD_ST_WR_LOW: begin
        pins_next.ce_n = 1'b0;
        pins_next.we_n = 1'b0;
        pins_next.dq_o = req_use.word_mode ? req_use.wdata : (low_addr_pin | req_use.wdata);
        pins_next.dq_oe = wr_oe;
      end
      FBD_ST_RD: begin
        pins_next.ce_n = 1'b0;
        pins_next.oe_n = 1'b0;
        pins_next.hv_select_en = hv_op;
        pins_next.dq_o = low_addr_pin;
        pins_next.dq_oe = rd_oe;
      end
      default: begin
        pins_next.ce_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FBD_ST_RST;
      pins_reg <= PINS_RESET;
    end else begin
      state_reg <= state_next;
      pins_reg <= pins_next;
    end
  end

  // Startup flags: full first reset pulse, no answer for it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      started_reg <= 1'b0;
      boot_reg <= 1'b1;
    end else begin
      started_reg <= 1'b1;
      if (state_reg == FBD_ST_IDLE) begin
        boot_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= '{op: FBD_OP_READ, word_mode: 1'b1, addr: '0, wdata: '0};
    end else if (take) begin
      req_reg <= req;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_data_reg <= '0;
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= (state_next == FBD_ST_DONE) && !boot_reg;
      if (sample) begin
        rsp_data_reg <= rd_word;
      end
    end
  end

  // Checks
  localparam int MAX_LAT = 300;
  logic [CNT_W-1:0] rp_low_cnt;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rp_low_cnt <= '0;
    end else if (!pins_reg.reset_unprotect_n) begin
      rp_low_cnt <= rp_low_cnt + 1'b1;
    end else begin
      rp_low_cnt <= '0;
    end
  end

  sequence s_strobe_low;
    !pins_reg.we_n && !pins_reg.ce_n && pins_reg.oe_n;
  endsequence

  sequence s_strobe_rise;
    pins_reg.we_n && !pins_reg.ce_n;
  endsequence

  property p_no_gate_strobe;
    @(posedge clock) disable iff (!rst_n) !(!pins_reg.oe_n && !pins_reg.we_n);
  endproperty
  a_no_gate_strobe: assert property (p_no_gate_strobe) else $error("gate and strobe low");

  property p_write_cycle;
    @(posedge clock) disable iff (!rst_n)
      $fell(pins_reg.we_n) |-> s_strobe_low [*3] ##1 s_strobe_rise;
  endproperty
  a_write_cycle: assert property (p_write_cycle) else $error("bad write cycle shape");

  property p_addr_stable;
    @(posedge clock) disable iff (!rst_n)
      (!pins_reg.we_n && !$fell(pins_reg.we_n)) |-> $stable(pins_reg.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in write");

  property p_data_held;
    @(posedge clock) disable iff (!rst_n)
      $rose(pins_reg.we_n) |-> $stable(pins_reg.dq_o) && !pins_reg.ce_n;
  endproperty
  a_data_held: assert property (p_data_held) else $error("data lost at strobe rise");

  property p_no_drive_on_read;
    @(posedge clock) disable iff (!rst_n)
      !pins_reg.oe_n |-> (pins_reg.dq_oe[DATA_W-2:0] == '0);
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("drive while gated");

  property p_sample_selected;
    @(posedge clock) disable iff (!rst_n)
      sample |-> !pins_reg.ce_n && !pins_reg.oe_n && pins_reg.reset_unprotect_n;
  endproperty
  a_sample_selected: assert property (p_sample_selected) else $error("sample while off");

  property p_id_addr;
    @(posedge clock) disable iff (!rst_n)
      (pins_reg.hv_select_en && !pins_reg.oe_n && req_reg.op == FBD_OP_SIG_HV)
      |-> !pins_reg.addr[A1_BIT] && (pins_reg.addr[A0_BIT] == req_reg.addr[1]);
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("bad id address");

  property p_byte_upper_zero;
    @(posedge clock) disable iff (!rst_n)
      $rose(rsp_valid) && !req_reg.word_mode && (req_reg.op != FBD_OP_WRITE)
      && (req_reg.op != FBD_OP_RESET) |-> rsp_data[DATA_W-1:8] == BYTE_ZERO;
  endproperty
  a_byte_upper_zero: assert property (p_byte_upper_zero) else $error("upper byte not zero");

  property p_rst_width;
    @(posedge clock) disable iff (!rst_n)
      $rose(pins_reg.reset_unprotect_n) |-> rp_low_cnt >= CNT_W'(RST_CYC);
  endproperty
  a_rst_width: assert property (p_rst_width) else $error("reset pulse too short");

  property p_latency;
    @(posedge clock) disable iff (!rst_n)
      take |-> ##[1:MAX_LAT] rsp_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("request not answered");

endmodule : fbd_host

/* rtl/fbd_pkg.sv */
// Shared types and constants for the flash bus operation host controller
package fbd_pkg;

  localparam int CLK_NS = 20;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;

  // Bus timing, figures in ns (plain defaults)
  localparam int T_SETUP_NS = 20;
  localparam int T_WE_LOW_NS = 60;
  localparam int T_HOLD_NS = 20;
  localparam int T_ACC_NS = 120;
  localparam int T_HV_SETTLE_NS = 1000;
  localparam int T_RST_LOW_NS = 500;
  localparam int T_RST_REC_NS = 1000;

  // Least times round up to whole cycles
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int HV_CYC = (T_HV_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC = (T_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_REC_CYC = (T_RST_REC_NS + CLK_NS - 1) / CLK_NS;

  // Fixed address bits for id and protection reads
  localparam int A0_BIT = 0;
  localparam int A1_BIT = 1;
  localparam int A6_BIT = 6;
  localparam int BLK_LSB = 12;
  localparam int BLK_W = 6;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    FBD_OP_READ,
    FBD_OP_WRITE,
    FBD_OP_SIG_HV,
    FBD_OP_PROT_VERIFY,
    FBD_OP_RESET
  } fbd_op_e;

  typedef enum logic [3:0] {
    FBD_ST_RST,
    FBD_ST_RST_REC,
    FBD_ST_IDLE,
    FBD_ST_HV,
    FBD_ST_WR_SETUP,
    FBD_ST_WR_LOW,
    FBD_ST_WR_HOLD,
    FBD_ST_RD,
    FBD_ST_DONE
  } fbd_state_e;

  // Request: addr is a byte address, bit 0 is the byte-mode low address
  typedef struct packed {
    fbd_op_e op;
    logic word_mode;
    logic [ADDR_W:0] addr;
    logic [DATA_W-1:0] wdata;
  } fbd_req_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_unprotect_n;
    logic word_sel;
    logic hv_select_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic [DATA_W-1:0] dq_oe;
  } fbd_pins_s;

  localparam fbd_pins_s PINS_RESET = '{
    ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_unprotect_n: 1'b0,
    word_sel: 1'b1, hv_select_en: 1'b0, addr: '0, dq_o: '0, dq_oe: '0};

endpackage : fbd_pkg

/* rtl/fbd_timer.sv */
// Loadable down counter used to time bus phases
`timescale 1ns/10ps
module fbd_timer #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);

  logic [W-1:0] count_reg;

  assign done = (count_reg == '0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= value;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule : fbd_timer

/* verif/fbd_flash_model.sv */
// Behavioural flash device answering the host pins
`timescale 1ns/10ps
module fbd_flash_model
  import fbd_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hc3, // Arbitrary value
  parameter logic [63:0] PROT = 64'h0000_0000_0000_0004
) (
  input wire logic clock,
  input wire fbd_pkg::fbd_pins_s pins,
  output logic [fbd_pkg::DATA_W-1:0] dq_i
);
  // Small array, upper address bits alias
  logic [7:0] mem [256];
  logic [15:0] last = 16'h0000;
  logic [15:0] dev_d;
  logic sig_mode = 1'b0;
  logic wr_on = 1'b0;
  logic dev_on;
  logic [7:0] wa, ba, wb;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hff;
  assign ba = {pins.addr[6:0], pins.dq_o[15]};
  assign wb = {pins.addr[6:0], 1'b0};
  assign dev_on = !pins.ce_n && !pins.oe_n && pins.reset_unprotect_n;
  always_comb begin
    if (pins.hv_select_en || sig_mode) begin
      dev_d[7:0] = pins.addr[1] ? {7'h00, PROT[pins.addr[17:12]]} :
          (pins.addr[0] ? DEV_CODE : MFR_CODE);
      dev_d[15:8] = 8'h00;
    end else begin
      dev_d = pins.word_sel ? {mem[wb + 8'h01], mem[wb]} : {8'h00, mem[ba]};
    end
    // Released lines show the inverse of their last level
    for (int i = 0; i < 16; i++) begin
      dq_i[i] = pins.dq_oe[i] ? pins.dq_o[i] :
          (dev_on && (pins.word_sel || i < 8)) ? dev_d[i] : ~last[i];
    end
  end
  always @(posedge clock) last <= dq_i;
  always @(negedge pins.we_n or negedge pins.ce_n) begin
    if (!pins.we_n && !pins.ce_n && pins.oe_n) begin
      wr_on <= 1'b1;
      wa <= pins.word_sel ? wb : ba;
    end
  end
  // Simplified: 90h and F0h switch mode, other writes program
  always @(posedge pins.we_n or posedge pins.ce_n) begin
    if (wr_on) begin
      wr_on <= 1'b0;
      if (dq_i[7:0] == 8'h90) sig_mode <= 1'b1;
      else if (dq_i[7:0] == 8'hf0) sig_mode <= 1'b0;
      else begin
        mem[wa] <= dq_i[7:0];
        if (pins.word_sel) mem[wa + 8'h01] <= dq_i[15:8];
      end
    end
  end
  always @(negedge pins.reset_unprotect_n) sig_mode <= 1'b0;
endmodule : fbd_flash_model

/* verif/flash_bus_operation_decoder_test.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
module flash_bus_operation_decoder_test;
  import fbd_pkg::*;
  localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
  localparam logic [7:0] DEV = 8'hc3; // Arbitrary value
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  fbd_req_s req = '0;
  logic req_valid = 1'b0;
  logic req_ready, rsp_valid;
  logic [DATA_W-1:0] rsp_data, dq_i;
  fbd_pins_s pins;
  int fails = 0;
  int total_checks = 0;
  int rst_low = 0;
  fbd_host fbd_host_inst (.clock(clock), .rst_n(rst_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .pins(pins),
    .dq_i(dq_i));
  fbd_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .PROT(64'h0000_0001_0000_0000))
    fbd_flash_model_inst (.clock(clock), .pins(pins), .dq_i(dq_i));
  always #10 clock = ~clock;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Gate and strobe never low together
  always @(posedge clock) if (rst_n && !pins.oe_n && !pins.we_n) check(16'h0000, 16'h0003);

  // One request, bounded wait, result compared for reads
  task automatic op(input fbd_op_e o, input logic wm, input logic [ADDR_W:0] a,
                    input logic [15:0] wd, input logic [15:0] exp);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1 n++;
    end
    req = '{op: o, word_mode: wm, addr: a, wdata: wd};
    req_valid = 1'b1;
    @(posedge clock);
    #1 req_valid = 1'b0;
    rst_low = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      rst_low += (pins.reset_unprotect_n === 1'b0);
      @(posedge clock);
      #1 n++;
    end
    check(16'(n < 300), 16'h0001);
    if (o != FBD_OP_WRITE && o != FBD_OP_RESET) check(rsp_data, exp);
    @(posedge clock);
    #1 check(16'(pins.ce_n), 16'h0001);
  endtask : op

  task automatic t_reset;
    check({pins.ce_n, pins.oe_n, pins.we_n, pins.reset_unprotect_n}, 16'h000e);
    check(pins.dq_oe, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_word;
    op(FBD_OP_WRITE, 1'b1, 19'h0_0010, 16'h1234, 16'h0000);
    op(FBD_OP_WRITE, 1'b1, 19'h0_0012, 16'habcd, 16'h0000);
    op(FBD_OP_READ, 1'b1, 19'h0_0010, 16'h0000, 16'h1234);
    op(FBD_OP_READ, 1'b1, 19'h0_0012, 16'h0000, 16'habcd);
    $display("test word done");
  endtask : t_word

  task automatic t_byte;
    op(FBD_OP_WRITE, 1'b0, 19'h0_0021, 16'h005e, 16'h0000);
    op(FBD_OP_WRITE, 1'b0, 19'h0_0020, 16'h0071, 16'h0000);
    op(FBD_OP_READ, 1'b0, 19'h0_0021, 16'h0000, 16'h005e);
    op(FBD_OP_READ, 1'b0, 19'h0_0020, 16'h0000, 16'h0071);
    op(FBD_OP_READ, 1'b1, 19'h0_0020, 16'h0000, 16'h5e71);
    $display("test byte done");
  endtask : t_byte

  task automatic t_sig_hv;
    for (int m = 0; m < 4; m++) begin
      op(FBD_OP_SIG_HV, m[1], 19'(m[0] * 2), 16'h0000, {8'h00, m[0] ? DEV : MFR});
    end
    $display("test signature done");
  endtask : t_sig_hv

  task automatic t_query;
    op(FBD_OP_WRITE, 1'b1, 19'h0_aaaa, 16'h0090, 16'h0000);
    op(FBD_OP_READ, 1'b1, 19'h0_0000, 16'h0000, {8'h00, MFR});
    op(FBD_OP_READ, 1'b1, 19'h0_0002, 16'h0000, {8'h00, DEV});
    op(FBD_OP_READ, 1'b1, 19'h4_0004, 16'h0000, 16'h0001);
    op(FBD_OP_WRITE, 1'b1, 19'h0_aaaa, 16'h00f0, 16'h0000);
    op(FBD_OP_READ, 1'b1, 19'h0_0010, 16'h0000, 16'h1234);
    $display("test query done");
  endtask : t_query

  task automatic t_prot;
    op(FBD_OP_PROT_VERIFY, 1'b1, 19'h4_0000, 16'h0000, 16'h0001);
    op(FBD_OP_PROT_VERIFY, 1'b1, 19'h6_0000, 16'h0000, 16'h0000);
    $display("test protect done");
  endtask : t_prot

  task automatic t_rst_op;
    op(FBD_OP_WRITE, 1'b1, 19'h0_aaaa, 16'h0090, 16'h0000);
    op(FBD_OP_RESET, 1'b1, 19'h0_0000, 16'h0000, 16'h0000);
    check(16'(rst_low >= RST_CYC), 16'h0001);
    op(FBD_OP_READ, 1'b1, 19'h0_0010, 16'h0000, 16'h1234);
    $display("test reset op done");
  endtask : t_rst_op

  initial begin
    repeat (8) @(posedge clock);
    t_reset;
    #1 rst_n = 1'b1;
    t_word;
    t_byte;
    t_sig_hv;
    t_query;
    t_prot;
    t_rst_op;
    stop_test;
  end

  initial begin
    #400_000;
    fails++;
    stop_test;
  end
endmodule : flash_bus_operation_decoder_test
